// >>> acq_trigger_control.sv
// Acquisition sequencer: free-run, paced, single and burst triggering
//
// Overview of operation
// - Free-run starts each exposure by itself without trigger, as soon as possible unless pacing is on.
// - Free-run without pacing exposes the next frame while the previous frame reads out.
// - With pacing on, internal pulses at the set rate start frames in free-run and burst modes.
// - With pacing on, exposure never overlaps readout.
// - Triggered modes stay idle until a valid trigger arrives.
// - Single trigger exposes one frame, then reads that frame out.
// - Trigger input is selectable as edge or level sensitive.
// - A level trigger may set exposure length or gate acquisition.
// - Software command acts as an edge trigger like the hardware inputs, never as a level trigger.
// - Hardware inputs trigger with higher fixed latency than software.
// - Optional debounce with enable and time; reset clears the enable, which follows its setting one cycle later.
// - Trigger delay: 2 us/40 us on first input, under 1 us on second.
// - Exposure-active output rises with exposure start, no delay.
// - Minimum trigger period is delay plus exposure plus readout; free-run reports exposure plus readout only.
// - Reported frame rate is the reciprocal of the minimum trigger period.
// - Burst start: each trigger launches a set count of paced frames.
// - Burst active: frames captured while the trigger level is active.
// - Burst modes only work while pacing is selected.
// - Exposure is clamped to minimum, maximum and step size.
// - Gain may be quantized to discrete steps.
`timescale 1ns/100ps
`default_nettype none

module acq_trigger_control
  import acq_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // Acquisition settings
  input  wire logic [1:0]        acq_mode_in,
  input  wire logic              frame_rate_enable_in,
  input  wire logic [US_W-1:0]   frame_period_setting_in,
  input  wire logic [7:0]        burst_count_setting_in,
  input  wire logic [US_W-1:0]   exposure_time_setting_in,
  input  wire logic [US_W-1:0]   readout_time_setting_in,
  input  wire logic [GAIN_W-1:0] gain_setting_in,
  input  wire logic              gain_step_enable_in,
  // Trigger settings
  input  wire logic [1:0]        trigger_source_in,
  input  wire logic              trigger_level_mode_in,
  input  wire logic              trigger_invert_in,
  input  wire logic              level_exposure_in,
  input  wire logic              debounce_enable_setting_in,
  input  wire logic [15:0]       debounce_time_setting_in,
  // Trigger inputs
  input  wire logic              software_trigger_in,
  input  wire logic              first_general_input_in,
  input  wire logic              second_general_input_in,
  // Sensor timing
  output logic                   exposure_active_out,
  output logic                   readout_active_out,
  output logic                   frame_start_out,
  output logic                   trigger_ignored_out,
  // Readback
  output logic [US_W-1:0]        exposure_applied_out,
  output logic [GAIN_W-1:0]      gain_applied_out,
  output logic [31:0]            min_trigger_period_out,
  output logic [31:0]            frame_rate_readback_out
);

  // ==========================================================
  // State
  typedef struct packed {
    trig_state_t       tstate;
    logic [DLY_W-1:0]  dly_cnt;
    logic              prev_level;
    logic              exp_busy;
    logic              exp_by_level;
    logic              exp_wait;
    logic [CNT_W-1:0]  exp_cnt;
    logic              rd_busy;
    logic [CNT_W-1:0]  rd_cnt;
    logic [CNT_W-1:0]  pace_cnt;
    logic [7:0]        burst_left;
    logic              frame_start;
    logic              trig_ignored;
    logic [US_W-1:0]   exp_applied;
    logic [GAIN_W-1:0] gain_applied;
    logic [31:0]       min_period;
    logic [5:0]        div_step;
    logic [32:0]       div_rem;
    logic [31:0]       div_quo;
    logic [31:0]       div_den;
    logic [31:0]       fps;
  } acq_state_t;

  acq_state_t s;
  acq_state_t next_s;

  // ==========================================================
  // Helpers
  function automatic logic [US_W-1:0] quantize(
    input logic [US_W-1:0] value,
    input logic [US_W-1:0] step
  );
    quantize = value - (value % step);
  endfunction

  function automatic logic [CNT_W-1:0] to_cycles(input logic [US_W-1:0] us);
    logic [CNT_W-1:0] cyc;
    cyc = CNT_W'(us * US_CYCLES);
    if (cyc == '0)
    begin
      cyc = CNT_W'(1);
    end
    to_cycles = cyc;
  endfunction

  // ==========================================================
  // Settings decode
  acq_mode_t        mode_eff;
  trig_src_t        src;
  logic [US_W-1:0]  exp_clamped;
  logic [US_W-1:0]  exp_us;
  logic [CNT_W-1:0] exp_cycles;
  logic [CNT_W-1:0] rd_cycles;
  logic [CNT_W-1:0] period_cycles;
  logic [GAIN_W-1:0] gain_q;

  assign src = trig_src_t'(trigger_source_in);

  always_comb
  begin
    mode_eff = acq_mode_t'(acq_mode_in);
    if ((mode_eff == MODE_BURST_START || mode_eff == MODE_BURST_ACTIVE)
        && !frame_rate_enable_in)
    begin
      mode_eff = MODE_SINGLE;
    end
  end

  always_comb
  begin
    exp_clamped = exposure_time_setting_in;
    if (exp_clamped < EXP_MIN_US)
    begin
      exp_clamped = EXP_MIN_US;
    end
    else if (exp_clamped > EXP_MAX_US)
    begin
      exp_clamped = EXP_MAX_US;
    end
  end

  assign exp_us        = quantize(exp_clamped, EXP_STEP_US);
  assign exp_cycles    = to_cycles(exp_us);
  assign rd_cycles     = to_cycles(readout_time_setting_in);
  assign period_cycles = to_cycles(frame_period_setting_in);
  assign gain_q        = GAIN_W'(quantize(US_W'(gain_setting_in), GAIN_STEP));

  // ==========================================================
  // Trigger detection
  logic             hw_raw;
  logic             hw_deb;
  logic             is_hw;
  logic             level_now;
  logic             act_edge;
  logic [DLY_W-1:0] dly_sel;
  logic [31:0]      dly_ns;

  assign is_hw  = (src == SRC_FIRST) || (src == SRC_SECOND);
  assign hw_raw = (src == SRC_FIRST) ? first_general_input_in
                                     : second_general_input_in;

  input_debounce u_debounce (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .enable_in    (debounce_enable_setting_in),
    .time_us_in   (debounce_time_setting_in),
    .raw_in       (hw_raw),
    .filtered_out (hw_deb)
  );

  assign level_now = is_hw && (hw_deb ^ trigger_invert_in);
  // Software command is an edge-only source
  assign act_edge  = is_hw ? (level_now && !s.prev_level)
                           : (src == SRC_SOFTWARE) && software_trigger_in;

  always_comb
  begin
    case (src)
      SRC_FIRST:
      begin
        // Active edge on an inverted input is the physical falling edge
        dly_sel = trigger_invert_in ? FIRST_FALL_CYCLES : FIRST_RISE_CYCLES;
        dly_ns  = trigger_invert_in ? 32'(FIRST_FALL_DELAY_NS)
                                    : 32'(FIRST_RISE_DELAY_NS);
      end
      SRC_SECOND:
      begin
        dly_sel = SECOND_CYCLES;
        dly_ns  = 32'(SECOND_DELAY_NS);
      end
      default:
      begin
        dly_sel = SOFT_CYCLES;
        dly_ns  = 32'(SOFT_DELAY_NS);
      end
    endcase
  end

  // ==========================================================
  // Sequencer
  logic       frames_idle;
  logic       pace_tick;
  logic       start;
  logic       by_level;
  logic       exp_end;
  logic       rd_free;
  logic [32:0] div_sh;
  logic       div_bit;

  assign frames_idle = !s.exp_busy && !s.exp_wait && !s.rd_busy;
  assign pace_tick   = frame_rate_enable_in && (s.pace_cnt == '0);
  assign exp_end     = s.exp_busy && (s.exp_by_level ? !level_now
                                                     : (s.exp_cnt == '0));
  assign rd_free     = !s.rd_busy || ((s.rd_cnt == '0) && !s.exp_wait);

  always_comb
  begin
    next_s              = s;
    start               = 1'b0;
    by_level            = 1'b0;
    div_sh              = '0;
    div_bit             = 1'b0;
    next_s.frame_start  = 1'b0;
    next_s.trig_ignored = 1'b0;
    next_s.prev_level   = level_now;

    // Internal pacing pulses
    if (!frame_rate_enable_in)
    begin
      next_s.pace_cnt = '0;
    end
    else if (pace_tick)
    begin
      next_s.pace_cnt = period_cycles - CNT_W'(1);
    end
    else
    begin
      next_s.pace_cnt = s.pace_cnt - CNT_W'(1);
    end

    // Frame launch per mode
    case (mode_eff)
      MODE_FREE_RUN:
      begin
        if (frame_rate_enable_in)
        begin
          start = pace_tick && frames_idle;
        end
        else
        begin
          start = !s.exp_busy && !s.exp_wait;
        end
      end
      MODE_SINGLE:
      begin
        if (act_edge)
        begin
          if (frames_idle && s.tstate == TS_IDLE)
          begin
            next_s.tstate  = TS_DELAY;
            next_s.dly_cnt = dly_sel - DLY_W'(1);
          end
          else
          begin
            next_s.trig_ignored = 1'b1;
          end
        end
      end
      MODE_BURST_START:
      begin
        if (act_edge)
        begin
          if (s.burst_left == '0 && s.tstate == TS_IDLE)
          begin
            next_s.tstate  = TS_DELAY;
            next_s.dly_cnt = dly_sel - DLY_W'(1);
          end
          else
          begin
            next_s.trig_ignored = 1'b1;
          end
        end
        if (s.burst_left != '0 && pace_tick && frames_idle)
        begin
          start             = 1'b1;
          next_s.burst_left = s.burst_left - 8'h01;
        end
      end
      MODE_BURST_ACTIVE:
      begin
        start = trigger_level_mode_in && level_now
                && pace_tick && frames_idle;
      end
      default:
      begin
        start = 1'b0;
      end
    endcase

    // Trigger to exposure delay
    if (s.tstate == TS_DELAY)
    begin
      if (s.dly_cnt == '0)
      begin
        next_s.tstate = TS_IDLE;
        if (mode_eff == MODE_SINGLE)
        begin
          start    = 1'b1;
          by_level = trigger_level_mode_in && level_exposure_in
                     && level_now;
        end
        else if (mode_eff == MODE_BURST_START)
        begin
          next_s.burst_left = burst_count_setting_in;
          next_s.pace_cnt   = '0;
        end
      end
      else
      begin
        next_s.dly_cnt = s.dly_cnt - DLY_W'(1);
      end
    end

    // Readout timing
    if (s.rd_busy)
    begin
      if (s.rd_cnt == '0)
      begin
        if (s.exp_wait)
        begin
          next_s.rd_cnt   = rd_cycles - CNT_W'(1);
          next_s.exp_wait = 1'b0;
        end
        else
        begin
          next_s.rd_busy = 1'b0;
        end
      end
      else
      begin
        next_s.rd_cnt = s.rd_cnt - CNT_W'(1);
      end
    end

    // Exposure end hands the frame to readout
    if (exp_end)
    begin
      next_s.exp_busy = 1'b0;
      if (rd_free)
      begin
        next_s.rd_busy = 1'b1;
        next_s.rd_cnt  = rd_cycles - CNT_W'(1);
      end
      else
      begin
        next_s.exp_wait = 1'b1;
      end
    end
    else if (s.exp_busy && !s.exp_by_level)
    begin
      next_s.exp_cnt = s.exp_cnt - CNT_W'(1);
    end

    // Exposure start
    if (start)
    begin
      next_s.exp_busy     = 1'b1;
      next_s.exp_cnt      = exp_cycles - CNT_W'(1);
      next_s.exp_by_level = by_level;
      next_s.frame_start  = 1'b1;
    end

    // Readback of applied settings
    next_s.exp_applied  = exp_us;
    next_s.gain_applied = gain_step_enable_in ? gain_q : gain_setting_in;
    next_s.min_period   = ((mode_eff == MODE_FREE_RUN) ? 32'h00000000 : dly_ns)
                          + 32'(exp_us) * NS_PER_US
                          + 32'(readout_time_setting_in) * NS_PER_US;

    // Frame rate as reciprocal of the minimum period
    if (s.div_step == '0)
    begin
      next_s.div_den  = s.min_period;
      next_s.div_rem  = '0;
      next_s.div_quo  = FPS_DIVIDEND;
      next_s.div_step = 6'h01;
    end
    else
    begin
      div_sh = {s.div_rem[31:0], s.div_quo[31]};
      if (div_sh >= {1'b0, s.div_den})
      begin
        div_sh  = div_sh - {1'b0, s.div_den};
        div_bit = 1'b1;
      end
      next_s.div_rem = div_sh;
      next_s.div_quo = {s.div_quo[30:0], div_bit};
      if (s.div_step == 6'h20)
      begin
        next_s.fps      = {s.div_quo[30:0], div_bit};
        next_s.div_step = '0;
      end
      else
      begin
        next_s.div_step = s.div_step + 6'h01;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s            <= '0;
      s.prev_level <= is_hw && (hw_raw ^ trigger_invert_in);
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign exposure_active_out     = s.exp_busy;
  assign readout_active_out      = s.rd_busy;
  assign frame_start_out         = s.frame_start;
  assign trigger_ignored_out     = s.trig_ignored;
  assign exposure_applied_out    = s.exp_applied;
  assign gain_applied_out        = s.gain_applied;
  assign min_trigger_period_out  = s.min_period;
  assign frame_rate_readback_out = s.fps;

endmodule

`default_nettype wire

// >>> acq_pkg.sv
// Shared constants and types for the acquisition trigger sequencer
package acq_pkg;

  // ==========================================================
  // Clock and widths
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          US_CYCLES     = 1000 / CLK_PERIOD_NS;
  localparam int          CNT_W         = 27;
  localparam int          DLY_W         = 12;
  localparam int          US_W          = 20;
  localparam int          GAIN_W        = 12;

  // ==========================================================
  // Trigger to exposure delays, in ns and in cycles
  localparam int          FIRST_RISE_DELAY_NS  = 2000;
  localparam int          FIRST_FALL_DELAY_NS  = 40000;
  localparam int          SECOND_DELAY_NS      = 1000;
  localparam int          SOFT_DELAY_NS        = 10;
  localparam logic [DLY_W-1:0] FIRST_RISE_CYCLES =
    DLY_W'(FIRST_RISE_DELAY_NS / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] FIRST_FALL_CYCLES =
    DLY_W'(FIRST_FALL_DELAY_NS / CLK_PERIOD_NS);
  // Strictly under the printed bound
  localparam logic [DLY_W-1:0] SECOND_CYCLES =
    DLY_W'(SECOND_DELAY_NS / CLK_PERIOD_NS - 1);
  localparam logic [DLY_W-1:0] SOFT_CYCLES =
    DLY_W'((SOFT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // Exposure and gain limits
  localparam int          ROW_TIME_NS   = 10000;
  localparam logic [US_W-1:0] EXP_MIN_US = US_W'((ROW_TIME_NS + 999) / 1000);
  localparam logic [US_W-1:0] EXP_MAX_US = 20'hf4240;
  localparam logic [US_W-1:0] EXP_STEP_US = 20'h0000a;
  localparam logic [US_W-1:0] GAIN_STEP   = 20'h00010;
  localparam logic [31:0] NS_PER_US     = 32'h000003e8;
  localparam logic [31:0] FPS_DIVIDEND  = 32'h3b9aca00;
  localparam logic        DEBOUNCE_EN_RESET = 1'b0;

  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    MODE_FREE_RUN     = 2'b00,
    MODE_SINGLE       = 2'b01,
    MODE_BURST_START  = 2'b10,
    MODE_BURST_ACTIVE = 2'b11
  } acq_mode_t;

  typedef enum logic [1:0] {
    SRC_SOFTWARE = 2'b00,
    SRC_FIRST    = 2'b01,
    SRC_SECOND   = 2'b10,
    SRC_NONE     = 2'b11
  } trig_src_t;

  typedef enum logic [0:0] {
    TS_IDLE  = 1'b0,
    TS_DELAY = 1'b1
  } trig_state_t;

endpackage

// >>> input_debounce.sv
// Optional debounce filter for the selected trigger input
`timescale 1ns/100ps
`default_nettype none

module input_debounce
  import acq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Settings
  input  wire logic        enable_in,
  input  wire logic [15:0] time_us_in,
  // Signal
  input  wire logic        raw_in,
  output logic             filtered_out
);

  typedef struct packed {
    logic        en;
    logic        level;
    logic [22:0] cnt;
  } deb_state_t;

  deb_state_t s;
  deb_state_t next_s;
  logic [22:0] limit;

  assign limit = 23'(time_us_in * US_CYCLES);

  // ==========================================================
  // Filter
  always_comb
  begin
    next_s    = s;
    next_s.en = enable_in;
    if (!s.en || raw_in == s.level)
    begin
      next_s.level = raw_in;
      next_s.cnt   = '0;
    end
    else if (s.cnt >= limit)
    begin
      next_s.level = raw_in;
      next_s.cnt   = '0;
    end
    else
    begin
      next_s.cnt = s.cnt + 23'h000001;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s       <= '0;
      s.en    <= DEBOUNCE_EN_RESET;
      // Track the pin so no false edge follows reset
      s.level <= raw_in;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign filtered_out = s.level;

endmodule

`default_nettype wire

// >>> acq_trigger_control_props.sv
// Port-level assertions for the acquisition sequencer
`timescale 1ns/100ps
`default_nettype none

module acq_trigger_control_props
  import acq_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  // Settings and triggers
  input  wire logic [1:0]      acq_mode_in,
  input  wire logic            frame_rate_enable_in,
  input  wire logic [US_W-1:0] readout_time_setting_in,
  input  wire logic [1:0]      trigger_source_in,
  input  wire logic            trigger_level_mode_in,
  input  wire logic            software_trigger_in,
  // Observed outputs
  input  wire logic            exposure_active_out,
  input  wire logic            readout_active_out,
  input  wire logic            frame_start_out,
  input  wire logic [US_W-1:0] exposure_applied_out
);
  logic [31:0] exp_cnt;
  logic [31:0] rd_cnt;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // ==========================================================
  // Length counters
  always_ff @(posedge clk_in)
  begin
    exp_cnt <= (exposure_active_out && !rst_in) ? exp_cnt + 32'h1 : 32'h0;
    rd_cnt  <= (readout_active_out && !rst_in) ? rd_cnt + 32'h1 : 32'h0;
  end

  // ==========================================================
  // Properties
  property p_exp_start;
    $rose(exposure_active_out) |-> frame_start_out;
  endproperty
  a_exp_start: assert property (p_exp_start)
    else $error("exposure began without frame start");

  property p_start_pulse;
    frame_start_out |-> exposure_active_out ##1 !frame_start_out;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("frame start not a single cycle");

  property p_sw_delay;
    (acq_mode_in == 2'b01) && !frame_rate_enable_in && (trigger_source_in == 2'b00)
      && $stable(trigger_source_in) && software_trigger_in && !$past(software_trigger_in)
      && !$past(software_trigger_in, 2) && !exposure_active_out && !readout_active_out
      |-> ##2 $rose(exposure_active_out);
  endproperty
  a_sw_delay: assert property (p_sw_delay)
    else $error("software trigger latency wrong");

  property p_no_overlap;
    frame_rate_enable_in && $past(frame_rate_enable_in)
      |-> !(exposure_active_out && readout_active_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("paced exposure overlaps readout");

  property p_order;
    $fell(exposure_active_out) |-> readout_active_out;
  endproperty
  a_order: assert property (p_order)
    else $error("readout did not follow exposure");

  property p_exp_len;
    $fell(exposure_active_out) && !trigger_level_mode_in
      |-> exp_cnt == 32'(exposure_applied_out) * 32'd100;
  endproperty
  a_exp_len: assert property (p_exp_len)
    else $error("exposure length differs from applied time");

  property p_rd_len;
    $fell(readout_active_out) && (acq_mode_in != 2'b00 || frame_rate_enable_in)
      && (readout_time_setting_in != '0)
      |-> rd_cnt == 32'(readout_time_setting_in) * 32'd100;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("readout length differs from setting");

  property p_free_run;
    (acq_mode_in == 2'b00) && !frame_rate_enable_in && (readout_time_setting_in <= 20'h5)
      && $fell(exposure_active_out) |-> ##[1:2] $rose(exposure_active_out);
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("free-run did not restart exposure");
endmodule

bind acq_trigger_control acq_trigger_control_props u_props (.clk_in, .rst_in, .acq_mode_in,
  .frame_rate_enable_in, .readout_time_setting_in, .trigger_source_in, .trigger_level_mode_in,
  .software_trigger_in, .exposure_active_out, .readout_active_out, .frame_start_out,
  .exposure_applied_out);

`default_nettype wire

// >>> trig_source_model.sv
// Host command and external trigger line model
`timescale 1ns/100ps
`default_nettype none

module trig_source_model
(
  // Clock
  input  wire logic clk_in,
  // Trigger outputs
  output var logic  software_trigger_out,
  output var logic  first_general_input_out,
  output var logic  second_general_input_out
);
  initial
  begin
    software_trigger_out = 1'b0;
    first_general_input_out = 1'b0;
    second_general_input_out = 1'b0;
  end

  // Host command pulse, entered at a falling edge
  task automatic soft_pulse();
    software_trigger_out = 1'b1;
    @(negedge clk_in);
    software_trigger_out = 1'b0;
  endtask

  // Clean external level, held until changed
  task automatic set_line(input logic second, input logic val);
    if (second)
      second_general_input_out = val;
    else
      first_general_input_out = val;
  endtask
endmodule

`default_nettype wire

// >>> acq_trigger_control_tb_top.sv
// Self-checking bench for the acquisition sequencer
`timescale 1ns/100ps
`default_nettype none

module acq_trigger_control_tb_top
  import acq_pkg::*;
;
  logic            clk_in = 1'b0;
  logic            rst_in;
  logic [1:0]      acq_mode_in;
  logic            frame_rate_enable_in;
  logic [US_W-1:0] frame_period_setting_in;
  logic [7:0]      burst_count_setting_in;
  logic [US_W-1:0] exposure_time_setting_in;
  logic [US_W-1:0] readout_time_setting_in;
  logic [1:0]      trigger_source_in;
  logic            trigger_level_mode_in;
  logic            trigger_invert_in;
  logic            debounce_enable_setting_in;
  wire             software_trigger_in;
  wire             first_general_input_in;
  wire             second_general_input_in;
  wire             exposure_active_out;
  wire             readout_active_out;
  wire             frame_start_out;
  wire             trigger_ignored_out;
  wire [US_W-1:0]  exposure_applied_out;
  wire [GAIN_W-1:0] gain_applied_out;
  wire [31:0]      min_trigger_period_out;
  wire [31:0]      frame_rate_readback_out;
  int              err_total = 0;
  int              total_checks = 0;
  int              n;
  int              fs_n;
  int              ovl;
  int              g;
  int              exp_tab [3] = '{202, 4002, 101};

  always #5 clk_in = ~clk_in;

  trig_source_model src (.clk_in, .software_trigger_out(software_trigger_in),
    .first_general_input_out(first_general_input_in),
    .second_general_input_out(second_general_input_in));

  acq_trigger_control DUT (.clk_in, .rst_in, .acq_mode_in, .frame_rate_enable_in,
    .frame_period_setting_in, .burst_count_setting_in, .exposure_time_setting_in,
    .readout_time_setting_in, .gain_setting_in(12'h01f), .gain_step_enable_in(1'b1),
    .trigger_source_in, .trigger_level_mode_in, .trigger_invert_in, .level_exposure_in(1'b0),
    .debounce_enable_setting_in, .debounce_time_setting_in(16'h0002), .software_trigger_in,
    .first_general_input_in, .second_general_input_in, .exposure_active_out,
    .readout_active_out, .frame_start_out, .trigger_ignored_out, .exposure_applied_out,
    .gain_applied_out, .min_trigger_period_out, .frame_rate_readback_out);

  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv)
    begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, expv, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic rst();
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    fs_n = 0;
    ovl = 0;
  endtask

  task automatic step();
    @(negedge clk_in);
    if (frame_start_out === 1'b1)
      fs_n++;
    if (exposure_active_out === 1'b1 && readout_active_out === 1'b1)
      ovl = 1;
  endtask

  task automatic meas(input int start);
    n = start;
    while (exposure_active_out !== 1'b1 && n < 5000)
    begin
      step();
      n++;
    end
  endtask

  task automatic len(input logic rd);
    n = 0;
    while ((rd ? readout_active_out : exposure_active_out) === 1'b1 && n < 5000)
    begin
      step();
      n++;
    end
  endtask

  task automatic wait_fs();
    g = fs_n;
    n = 0;
    while (fs_n == g && n < 5000)
    begin
      step();
      n++;
    end
  endtask

  initial
  begin
    #1000000;
    err_total++;
    stop_test();
  end

  // ==========================================================
  // Tests
  initial
  begin
    {acq_mode_in, frame_rate_enable_in, trigger_source_in} = 5'b01000;
    {trigger_level_mode_in, trigger_invert_in, debounce_enable_setting_in} = 3'b000;
    frame_period_setting_in = 20'h00014;
    burst_count_setting_in = 8'h03;
    exposure_time_setting_in = 20'h0000a;
    readout_time_setting_in = 20'h00005;
    rst();
    chk("exposure_idle", exposure_active_out, 1'b0);
    @(negedge clk_in);
    chk("exposure_applied", exposure_applied_out, 20'h0000a);
    chk("gain_q", gain_applied_out, 12'h010);
    exposure_time_setting_in = 20'h00000;
    repeat (2) @(negedge clk_in);
    chk("exposure_min", exposure_applied_out, EXP_MIN_US);
    exposure_time_setting_in = 20'hfffff;
    repeat (2) @(negedge clk_in);
    chk("exposure_max", exposure_applied_out, EXP_MAX_US);
    exposure_time_setting_in = 20'h0000a;
    $display("test clamp done");
    rst();
    src.soft_pulse();
    meas(1);
    chk("soft_delay", n, 2);
    len(1'b0);
    chk("exposure_len", n, 1000);
    len(1'b1);
    chk("readout_len", n, 500);
    src.soft_pulse();
    repeat (10) step();
    src.soft_pulse();
    g = 0;
    repeat (3)
    begin
      g = g | (trigger_ignored_out === 1'b1);
      step();
    end
    chk("ignored", g, 1);
    fs_n = 0;
    repeat (1600) step();
    chk("no_queued_frame", fs_n, 0);
    $display("test single done");
    for (int i = 0; i < 3; i++)
    begin
      trigger_source_in = (i == 2) ? 2'b10 : 2'b01;
      trigger_invert_in = (i == 1);
      src.set_line(i == 2, i == 1);
      rst();
      src.set_line(i == 2, i != 1);
      meas(0);
      chk("hw_delay", n, exp_tab[i]);
    end
    {trigger_invert_in, debounce_enable_setting_in} = 2'b01;
    src.set_line(1'b1, 1'b0);
    rst();
    @(negedge clk_in);
    src.set_line(1'b1, 1'b1);
    meas(0);
    chk("debounce_delay", n >= 300 && n <= 306, 1'b1);
    debounce_enable_setting_in = 1'b0;
    $display("test hw done");
    {acq_mode_in, trigger_source_in} = 4'b0011;
    rst();
    repeat (3000) step();
    chk("free_frames", fs_n, 3);
    chk("free_overlap", ovl, 1);
    chk("min_period", min_trigger_period_out, 32'(15) * NS_PER_US);
    repeat (100) @(negedge clk_in);
    chk("fps", frame_rate_readback_out, 32'd1000000000 / 32'd15000);
    $display("test free done");
    {acq_mode_in, frame_rate_enable_in} = 3'b001;
    rst();
    wait_fs();
    wait_fs();
    chk("pace_gap", n, 2000);
    chk("pace_overlap", ovl, 0);
    $display("test paced done");
    {acq_mode_in, trigger_source_in} = 4'b1000;
    rst();
    src.soft_pulse();
    repeat (7000) step();
    chk("burst_frames", fs_n, 3);
    frame_rate_enable_in = 1'b0;
    rst();
    src.soft_pulse();
    repeat (4000) step();
    chk("burst_unpaced", fs_n, 1);
    {acq_mode_in, frame_rate_enable_in, trigger_source_in, trigger_level_mode_in} = 6'b111011;
    src.set_line(1'b0, 1'b0);
    rst();
    src.set_line(1'b0, 1'b1);
    repeat (5000) step();
    chk("gate_frames", fs_n >= 2, 1'b1);
    src.set_line(1'b0, 1'b0);
    repeat (2500) step();
    fs_n = 0;
    repeat (5000) step();
    chk("gate_closed", fs_n, 0);
    $display("test burst done");
    stop_test();
  end
endmodule

`default_nettype wire
